/* design/wrc_pkg.sv */
/*
 wrc_pkg: shared constants and types of the wireless receiver communication encoder.
 assumes a 10 MHz core clock and a 32-bit AHB-Lite register bus.
*/
package wrc_pkg;
	// timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int BIT_PERIOD_NS = 500000;
	localparam int HALF_BIT_CYCLES = (BIT_PERIOD_NS / 2) / CLK_PERIOD_NS;

	// register byte offsets
	localparam logic [11:0] OFF_CTRL = 12'h000;
	localparam logic [11:0] OFF_TXDATA = 12'h004;
	localparam logic [11:0] OFF_STATUS = 12'h008;
	localparam logic [11:0] OFF_ILIM = 12'h00c;

	// field positions
	localparam int CTRL_OUT_EN_BIT = 0;
	localparam int CTRL_EPT_BIT = 1;
	localparam int CTRL_REASON_LSB = 8;
	localparam int TXDATA_LAST_BIT = 8;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

	// frame and packet
	localparam int FRAME_BITS = 11;
	localparam logic [7:0] HDR_EPT = 8'h02;
	localparam logic [7:0] HDR_RECT_PWR = 8'h04;

	// communication current limit, mA
	localparam int MA_W = 13;
	localparam logic [MA_W-1:0] LIM_THRESH_MA = 13'h012c;
	localparam logic [MA_W-1:0] LIM_FIXED_MA = 13'h0190;
	localparam logic [MA_W-1:0] LIM_MARGIN_MA = 13'h0032;

	typedef enum logic [1:0] {RECT_DIODE, RECT_HALF, RECT_FULL} wrc_rect_mode_t;

	typedef struct packed {
		logic last;
		logic [7:0] data;
	} wrc_byte_t;

	typedef struct packed {
		logic [1:0] rect_mode;
		logic limit_tracking;
		logic out_en;
		logic hold_full;
		logic pkt_active;
	} wrc_status_t;
endpackage

/* design/wrc_biphase_enc.sv */
/*
 wrc_biphase_enc: differential bi-phase bit encoder producing the modulation level.
 assumes the feeder keeps bit_valid_in and bit_in steady until take_out pulses.
*/
`timescale 1ns/1ps
module wrc_biphase_enc import wrc_pkg::*; #(
	parameter int HALF_CYC = HALF_BIT_CYCLES
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic ce_in,
	input wire logic bit_valid_in,
	input wire logic bit_in,
	output logic take_out,
	output logic busy_out,
	output logic level_out
);
	localparam int CW = $clog2(HALF_CYC);
	localparam logic [CW-1:0] CNT_LAST = CW'(HALF_CYC - 1);

	logic [CW-1:0] cnt_ff;
	logic second_ff;
	logic bit_ff;
	logic busy_ff;
	logic level_ff;
	logic end_half;
	logic bit_end;

	assign end_half = busy_ff && (cnt_ff == CNT_LAST);
	assign bit_end = end_half && second_ff;
	assign take_out = ce_in && bit_valid_in && (!busy_ff || bit_end);
	assign busy_out = busy_ff;
	assign level_out = level_ff;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cnt_ff <= '0;
			second_ff <= 1'b0;
			bit_ff <= 1'b0;
			busy_ff <= 1'b0;
			level_ff <= 1'b0;
		end else if (ce_in) begin
			if (!busy_ff || bit_end) begin
				if (bit_valid_in) begin
					busy_ff <= 1'b1;
					bit_ff <= bit_in;
					level_ff <= ~level_ff;
					cnt_ff <= '0;
					second_ff <= 1'b0;
				end else begin
					busy_ff <= 1'b0;
					level_ff <= 1'b0;
				end
			end else if (end_half) begin
				cnt_ff <= '0;
				second_ff <= 1'b1;
				if (bit_ff) begin
					level_ff <= ~level_ff;
				end
			end else begin
				cnt_ff <= cnt_ff + 1'b1;
			end
		end
	end

	// helper counts for the checks below; transitions are counted on the level itself,
	// so a missing toggle in the encoder cannot hide behind a mirrored condition
	logic [1:0] tog_cnt_ff;
	logic [CW:0] len_cnt_ff;
	logic level_q_ff;
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			tog_cnt_ff <= '0;
			len_cnt_ff <= '0;
			level_q_ff <= 1'b0;
		end else if (ce_in) begin
			level_q_ff <= level_ff;
			if (take_out) begin
				tog_cnt_ff <= 2'h0;
				len_cnt_ff <= '0;
			end else begin
				if (level_ff != level_q_ff) begin
					tog_cnt_ff <= tog_cnt_ff + 1'b1;
				end
				len_cnt_ff <= len_cnt_ff + 1'b1;
			end
		end
	end

	property p_bit_transitions;
		@(posedge clk_in) disable iff (!rst_n_in)
		(ce_in && bit_end) |-> (tog_cnt_ff == (bit_ff ? 2'h2 : 2'h1));
	endproperty
	a_bit_transitions: assert property (p_bit_transitions) else $error("wrong transition count in bit");

	property p_bit_length;
		@(posedge clk_in) disable iff (!rst_n_in)
		(ce_in && bit_end) |-> (len_cnt_ff == (CW+1)'(2 * HALF_CYC - 1));
	endproperty
	a_bit_length: assert property (p_bit_length) else $error("bit period length wrong");

	property p_boundary_toggle;
		@(posedge clk_in) disable iff (!rst_n_in)
		(take_out && busy_ff) |=> (level_ff != $past(level_ff));
	endproperty
	a_boundary_toggle: assert property (p_boundary_toggle) else $error("no toggle at bit boundary");
endmodule

/* design/wrc_rect_ctrl.sv */
/*
 wrc_rect_ctrl: rectifier mode sequencer, diode, half-synchronous and full-synchronous.
 assumes comparator levels already synchronous to the core clock.
*/
`timescale 1ns/1ps
module wrc_rect_ctrl import wrc_pkg::*; (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic ce_in,
	input wire logic above_uvlo_in,
	input wire logic above_sr_in,
	input wire logic below_srh_in,
	output wrc_rect_mode_t mode_out
);
	wrc_rect_mode_t mode_ff;

	assign mode_out = mode_ff;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			mode_ff <= RECT_DIODE;
		end else if (ce_in) begin
			// losing the uvlo level drops back to diode rectification
			case (mode_ff)
				RECT_DIODE: begin
					if (above_uvlo_in) begin
						mode_ff <= RECT_HALF;
					end
				end
				RECT_HALF: begin
					if (!above_uvlo_in) begin
						mode_ff <= RECT_DIODE;
					end else if (above_sr_in) begin
						mode_ff <= RECT_FULL;
					end
				end
				RECT_FULL: begin
					if (!above_uvlo_in) begin
						mode_ff <= RECT_DIODE;
					end else if (below_srh_in) begin
						mode_ff <= RECT_HALF;
					end
				end
				default: begin
					mode_ff <= RECT_DIODE;
				end
			endcase
		end
	end

	property p_startup_diode;
		@(posedge clk_in) disable iff (!rst_n_in)
		(ce_in && !above_uvlo_in) |=> (mode_ff == RECT_DIODE);
	endproperty
	a_startup_diode: assert property (p_startup_diode) else $error("sync rectifier on below uvlo");

	property p_half_entry;
		@(posedge clk_in) disable iff (!rst_n_in)
		(ce_in && mode_ff == RECT_DIODE && above_uvlo_in) |=> (mode_ff == RECT_HALF);
	endproperty
	a_half_entry: assert property (p_half_entry) else $error("half-sync mode not entered");

	property p_full_hold;
		@(posedge clk_in) disable iff (!rst_n_in)
		(ce_in && mode_ff == RECT_FULL && above_uvlo_in && !below_srh_in) |=> (mode_ff == RECT_FULL);
	endproperty
	a_full_hold: assert property (p_full_hold) else $error("full-sync left above hysteresis");
endmodule

/* design/wrc_top.sv */
/*
 wrc_top: receiver communication and control top: AHB-Lite registers, byte framing,
 bi-phase modulation drive, charge status, communication current limit, rectifier mode.
 assumes all inputs synchronous to MCLK_IN and a single AHB-Lite master.
*/
// The placing of the registers and the AHB-Lite interface to the registers were chosen for this implementation.
// Notes on behaviour
// - charge status pin on while supply enabled
// - supply stays off until regulation converged
// - each bit lasts 0.5 ms
// - one bit two transitions, zero one
// - bytes as 11-bit frames, lsb first
// - start, eight data, parity, stop
// - start zero, stop one, odd parity
// - rectified power packet header 0x04 sendable
// - end-transfer packet header 0x02 sendable
// - two identical switches follow encoded stream
// - both switches close together
// - below 300 mA fixed 400 mA limit
// - tracking limit is current plus 50 mA
// - limit applied only during a packet
// - start-up with diode rectification only
// - half-sync above uvlo until sr threshold
// - full-sync until below hysteresis threshold
`timescale 1ns/1ps
module wrc_top import wrc_pkg::*; #(
	parameter int HALF_CYC = HALF_BIT_CYCLES
) (
	// clock, reset, enable
	input wire logic MCLK_IN,
	input wire logic NRST_IN,
	input wire logic CE_IN,
	// ahb-lite slave
	input wire logic HSEL_IN,
	input wire logic [31:0] HADDR_IN,
	input wire logic [1:0] HTRANS_IN,
	input wire logic HWRITE_IN,
	input wire logic [2:0] HSIZE_IN,
	input wire logic [31:0] HWDATA_IN,
	input wire logic HREADY_IN,
	output logic [31:0] HRDATA_OUT,
	output logic HREADYOUT_OUT,
	output logic HRESP_OUT,
	// analog status levels
	input wire logic VRECT_CONVERGED_IN,
	input wire logic VRECT_ABOVE_UVLO_IN,
	input wire logic LOAD_ABOVE_FULL_SYNC_IN,
	input wire logic LOAD_BELOW_FULL_SYNC_EXIT_IN,
	input wire logic [MA_W-2:0] IOUT_MA_IN,
	// enable selects
	input wire logic ENABLE_SELECT_A_IN,
	input wire logic ENABLE_SELECT_B_IN,
	// charge status, open drain
	output logic CHARGE_STATUS_N_OUT,
	output logic CHARGE_STATUS_N_OE_OUT,
	// modulation switches
	output logic MODULATION_SWITCH_A_OUT,
	output logic MODULATION_SWITCH_B_OUT,
	// regulator and rectifier control
	output logic SUPPLY_OUT_EN_OUT,
	output logic COMM_LIMIT_EN_OUT,
	output logic [MA_W-1:0] COMM_LIMIT_MA_OUT,
	output logic [1:0] RECT_MODE_OUT
);
	localparam logic [3:0] FRAME_LEN = 4'(FRAME_BITS);

	function automatic logic [10:0] make_frame(input logic [7:0] data);
		make_frame = {1'b1, ~^data, data, 1'b0};
	endfunction

	function automatic logic [1:0] reg_sel(input logic [11:0] addr);
		case (addr)
			OFF_CTRL: reg_sel = 2'h0;
			OFF_TXDATA: reg_sel = 2'h1;
			OFF_STATUS: reg_sel = 2'h2;
			default: reg_sel = 2'h3;
		endcase
	endfunction

	// bus address and data phase
	logic dp_wr_ff;
	logic [11:0] dp_addr_ff;
	logic dp_hit_ff;
	logic addr_valid;
	logic wr_ctrl;
	logic wr_tx;

	assign addr_valid = HSEL_IN && HTRANS_IN[1] && HREADY_IN;
	assign wr_ctrl = CE_IN && dp_wr_ff && dp_hit_ff && (reg_sel(dp_addr_ff) == 2'h0);
	assign wr_tx = CE_IN && dp_wr_ff && dp_hit_ff && (reg_sel(dp_addr_ff) == 2'h1);

	logic [31:0] ctrl_ff;
	wrc_byte_t hold_ff;
	logic hold_full_ff;
	logic [1:0] ept_step_ff;
	logic [10:0] frame_ff;
	logic [3:0] bits_left_ff;
	logic cur_last_ff;
	logic pkt_active_ff;
	logic tracking_ff;
	wrc_rect_mode_t rect_mode;
	logic enc_take;
	logic enc_busy;
	logic enc_level;
	logic hold_pop;
	logic frame_load;
	logic limit_off;
	logic nxt_out_en;
	wrc_status_t status;

	assign status = '{rect_mode: rect_mode, limit_tracking: tracking_ff, out_en: SUPPLY_OUT_EN_OUT,
		hold_full: hold_full_ff, pkt_active: pkt_active_ff};

	always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			dp_wr_ff <= 1'b0;
			dp_addr_ff <= '0;
			dp_hit_ff <= 1'b0;
			HRDATA_OUT <= '0;
			HREADYOUT_OUT <= 1'b1;
			HRESP_OUT <= 1'b0;
		end else if (CE_IN) begin
			// a nonzero upper address hits no register and still gets an OKAY response, so it can never alias a register
			dp_hit_ff <= addr_valid && (HADDR_IN[31:12] == '0);
			dp_wr_ff <= addr_valid && HWRITE_IN;
			dp_addr_ff <= HADDR_IN[11:0];
			HREADYOUT_OUT <= 1'b1;
			HRESP_OUT <= 1'b0;
			if (addr_valid && !HWRITE_IN && (HADDR_IN[31:12] == '0)) begin
				case (reg_sel(HADDR_IN[11:0]))
					2'h0: HRDATA_OUT <= ctrl_ff;
					2'h1: HRDATA_OUT <= {23'h000000, hold_ff};
					2'h2: HRDATA_OUT <= {26'h0000000, status};
					default: HRDATA_OUT <= (HADDR_IN[11:0] == OFF_ILIM) ?
						{19'h00000, COMM_LIMIT_MA_OUT} : 32'h0000_0000;
				endcase
			end else begin
				HRDATA_OUT <= '0;
			end
		end
	end

	// control register; the ept bit is a self-clearing trigger
	always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			ctrl_ff <= CTRL_RESET;
		end else if (wr_ctrl) begin
			ctrl_ff <= HWDATA_IN & ~(32'h1 << CTRL_EPT_BIT);
		end
	end

	// holding byte: software writes while full are dropped, the
	// end-transfer sequencer only fills it when software is not writing
	always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			hold_ff <= '0;
			hold_full_ff <= 1'b0;
			ept_step_ff <= 2'h0;
		end else if (CE_IN) begin
			if (wr_ctrl && HWDATA_IN[CTRL_EPT_BIT] && ept_step_ff == 2'h0) begin
				ept_step_ff <= 2'h1;
			end
			if (hold_pop) begin
				hold_full_ff <= 1'b0;
			end
			if (!hold_full_ff && wr_tx) begin
				hold_ff <= '{last: HWDATA_IN[TXDATA_LAST_BIT], data: HWDATA_IN[7:0]};
				hold_full_ff <= 1'b1;
			end else if (!hold_full_ff && ept_step_ff == 2'h1) begin
				hold_ff <= '{last: 1'b0, data: HDR_EPT};
				hold_full_ff <= 1'b1;
				ept_step_ff <= 2'h2;
			end else if (!hold_full_ff && ept_step_ff == 2'h2) begin
				hold_ff <= '{last: 1'b1, data: ctrl_ff[CTRL_REASON_LSB +: 8]};
				hold_full_ff <= 1'b1;
				ept_step_ff <= 2'h0;
			end
		end
	end

	// frame shifter: next frame loads on the take of the stop bit so bits run back to back
	assign frame_load = hold_full_ff && ((bits_left_ff == 4'h0) || (enc_take && bits_left_ff == 4'h1));
	assign hold_pop = CE_IN && frame_load;

	always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			frame_ff <= '0;
			bits_left_ff <= 4'h0;
			cur_last_ff <= 1'b0;
		end else if (CE_IN) begin
			if (frame_load) begin
				frame_ff <= make_frame(hold_ff.data);
				bits_left_ff <= FRAME_LEN;
				cur_last_ff <= hold_ff.last;
			end else if (enc_take) begin
				frame_ff <= {1'b0, frame_ff[10:1]};
				bits_left_ff <= bits_left_ff - 4'h1;
			end
		end
	end

	always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			pkt_active_ff <= 1'b0;
		end else if (CE_IN) begin
			if (frame_load) begin
				pkt_active_ff <= 1'b1;
			end else if (!enc_busy && bits_left_ff == 4'h0 && cur_last_ff && !hold_full_ff) begin
				pkt_active_ff <= 1'b0;
			end
		end
	end

	wrc_biphase_enc #(
		.HALF_CYC(HALF_CYC)
	) wrc_biphase_enc_i (
		.clk_in(MCLK_IN),
		.rst_n_in(NRST_IN),
		.ce_in(CE_IN),
		.bit_valid_in(bits_left_ff != 4'h0),
		.bit_in(frame_ff[0]),
		.take_out(enc_take),
		.busy_out(enc_busy),
		.level_out(enc_level)
	);

	wrc_rect_ctrl wrc_rect_ctrl_i (
		.clk_in(MCLK_IN),
		.rst_n_in(NRST_IN),
		.ce_in(CE_IN),
		.above_uvlo_in(VRECT_ABOVE_UVLO_IN),
		.above_sr_in(LOAD_ABOVE_FULL_SYNC_IN),
		.below_srh_in(LOAD_BELOW_FULL_SYNC_EXIT_IN),
		.mode_out(rect_mode)
	);

	// both switches carry the same level so the coil sees both capacitors at once
	always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			MODULATION_SWITCH_A_OUT <= 1'b0;
			MODULATION_SWITCH_B_OUT <= 1'b0;
		end else if (CE_IN) begin
			MODULATION_SWITCH_A_OUT <= enc_level;
			MODULATION_SWITCH_B_OUT <= enc_level;
		end
	end

	assign nxt_out_en = ctrl_ff[CTRL_OUT_EN_BIT] && VRECT_CONVERGED_IN;

	always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			SUPPLY_OUT_EN_OUT <= 1'b0;
			CHARGE_STATUS_N_OUT <= 1'b0;
			CHARGE_STATUS_N_OE_OUT <= 1'b0;
			RECT_MODE_OUT <= 2'h0;
		end else if (CE_IN) begin
			SUPPLY_OUT_EN_OUT <= nxt_out_en;
			CHARGE_STATUS_N_OUT <= 1'b0;
			CHARGE_STATUS_N_OE_OUT <= nxt_out_en;
			RECT_MODE_OUT <= rect_mode;
		end
	end

	// limit tracks continuously; it only reaches the regulator during a packet
	assign limit_off = !ENABLE_SELECT_A_IN && ENABLE_SELECT_B_IN;

	always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			tracking_ff <= 1'b0;
			COMM_LIMIT_MA_OUT <= LIM_FIXED_MA;
			COMM_LIMIT_EN_OUT <= 1'b0;
		end else if (CE_IN) begin
			if ({1'b0, IOUT_MA_IN} > LIM_THRESH_MA) begin
				tracking_ff <= 1'b1;
				COMM_LIMIT_MA_OUT <= {1'b0, IOUT_MA_IN} + LIM_MARGIN_MA;
			end else begin
				tracking_ff <= 1'b0;
				COMM_LIMIT_MA_OUT <= LIM_FIXED_MA;
			end
			COMM_LIMIT_EN_OUT <= pkt_active_ff && !limit_off;
		end
	end

	// checks
	property p_chg_follows_supply;
		@(posedge MCLK_IN) disable iff (!NRST_IN)
		CE_IN |=> (CHARGE_STATUS_N_OE_OUT == SUPPLY_OUT_EN_OUT) && !CHARGE_STATUS_N_OUT;
	endproperty
	a_chg_follows_supply: assert property (p_chg_follows_supply) else $error("charge status mismatch");

	property p_no_supply_unconverged;
		@(posedge MCLK_IN) disable iff (!NRST_IN)
		(CE_IN && !VRECT_CONVERGED_IN) |=> !SUPPLY_OUT_EN_OUT;
	endproperty
	a_no_supply_unconverged: assert property (p_no_supply_unconverged) else $error("supply on unconverged");

	property p_frame_format;
		@(posedge MCLK_IN) disable iff (!NRST_IN)
		(CE_IN && frame_load) |=> (!frame_ff[0] && frame_ff[10] && (^frame_ff[9:1]) && bits_left_ff == 4'hb);
	endproperty
	a_frame_format: assert property (p_frame_format) else $error("bad frame format");

	property p_frame_payload;
		@(posedge MCLK_IN) disable iff (!NRST_IN)
		(CE_IN && frame_load) |=> (frame_ff[8:1] == $past(hold_ff.data));
	endproperty
	a_frame_payload: assert property (p_frame_payload) else $error("frame payload differs from held byte");

	property p_fixed_limit;
		@(posedge MCLK_IN) disable iff (!NRST_IN)
		(CE_IN && IOUT_MA_IN < 12'h12c) |=> (COMM_LIMIT_MA_OUT == 13'h0190);
	endproperty
	a_fixed_limit: assert property (p_fixed_limit) else $error("fixed limit wrong");

	property p_track_limit;
		@(posedge MCLK_IN) disable iff (!NRST_IN)
		(CE_IN && IOUT_MA_IN > 12'h12c) |=> (COMM_LIMIT_MA_OUT == {1'b0, $past(IOUT_MA_IN)} + 13'h0032);
	endproperty
	a_track_limit: assert property (p_track_limit) else $error("tracking limit wrong");

	property p_limit_in_packet;
		@(posedge MCLK_IN) disable iff (!NRST_IN)
		CE_IN |=> (COMM_LIMIT_EN_OUT == ($past(pkt_active_ff) && !$past(limit_off)));
	endproperty
	a_limit_in_packet: assert property (p_limit_in_packet) else $error("limit enable wrong");

	sequence s_quiet;
		!pkt_active_ff && !enc_busy && CE_IN;
	endsequence
	property p_idle_switches;
		@(posedge MCLK_IN) disable iff (!NRST_IN)
		s_quiet ##1 s_quiet |=> !MODULATION_SWITCH_A_OUT;
	endproperty
	a_idle_switches: assert property (p_idle_switches) else $error("switch active while idle");

	property p_switches_equal;
		@(posedge MCLK_IN) disable iff (!NRST_IN)
		MODULATION_SWITCH_A_OUT == MODULATION_SWITCH_B_OUT;
	endproperty
	a_switches_equal: assert property (p_switches_equal) else $error("switches differ");

	sequence s_far_write;
		CE_IN && addr_valid && HWRITE_IN && (HADDR_IN[31:12] != '0);
	endsequence
	property p_far_write_ignored;
		@(posedge MCLK_IN) disable iff (!NRST_IN)
		s_far_write ##1 CE_IN |=> (ctrl_ff == $past(ctrl_ff));
	endproperty
	a_far_write_ignored: assert property (p_far_write_ignored) else $error("unmapped write changed control");
endmodule

/* testbench/wrc_tx_decoder.sv */
/*
 wrc_tx_decoder: transmitter-side model that decodes the bi-phase load modulation into bytes.
 assumes the switches idle low and each half bit lasts HALF clock cycles.
*/
`timescale 1ns/1ps
module wrc_tx_decoder #(
	parameter int HALF = 4
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// modulation switches
	input wire logic sw_a_in,
	input wire logic sw_b_in,
	// decoded bytes
	output logic byte_valid_out,
	output logic [7:0] byte_out,
	output logic err_out
);
	int cnt;
	int idx;
	logic run, prv, h1, h2, ph2;
	logic [10:0] frm;
	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			run = 1'h0;
			prv = 1'h0;
			byte_valid_out <= 1'h0;
			byte_out <= 8'h00;
			err_out <= 1'h0;
		end else begin
			byte_valid_out <= 1'h0;
			err_out <= (sw_a_in !== sw_b_in);
			if (!run) begin
				if (sw_a_in === 1'h1 && prv === 1'h0) begin
					run = 1'h1;
					cnt = 0;
					idx = 0;
					ph2 = 1'h0;
				end
			end else begin
				cnt = (cnt == 2 * HALF - 1) ? 0 : cnt + 1;
				if (cnt == HALF / 2)
					h1 = sw_a_in;
				if (cnt == HALF + HALF / 2) begin
					h2 = sw_a_in;
					if (h1 === ph2) begin
						// no boundary toggle: line went idle, a fault only once two or more bits of a frame were decoded
						run = 1'h0;
						if (idx > 1)
							err_out <= 1'h1;
					end else begin
						frm[idx] = h1 ^ h2;
						ph2 = h2;
						idx++;
						if (idx == 11) begin
							idx = 0;
							byte_valid_out <= 1'h1;
							byte_out <= frm[8:1];
							if (frm[0] !== 1'h0 || frm[10] !== 1'h1 || ^frm[9:1] !== 1'h1)
								err_out <= 1'h1;
						end
					end
				end
			end
			prv = sw_a_in;
		end
	end
endmodule

/* testbench/test_wireless_rx_comm_encoder.sv */
/*
 test_wireless_rx_comm_encoder: self-checking bench for wrc_top with a decoding transmitter model.
 assumes a single AHB-Lite master and clock enable held high.
*/
`timescale 1ns/1ps
module test_wireless_rx_comm_encoder import wrc_pkg::*; ;
	localparam int HC = 4;
	logic clk;
	logic rst_n = 1'h0, hwrite = 1'h0, conv = 1'h0, uvlo = 1'h0, above = 1'h0, below = 1'h0, ena = 1'h0, enb = 1'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, s;
	logic [1:0] htrans = 2'h0;
	logic [11:0] iout = 12'h0c8;
	wire logic [31:0] hrdata;
	wire logic hready, hresp, charge_status_n, chg_oe, swa, swb, sup, lim_en, rx_v, rx_e;
	wire logic [12:0] lim_ma;
	wire logic [1:0] rmode;
	wire logic [7:0] rx_b;
	logic [7:0] rx_q[$];
	int num_errors = 0;
	int num_checks = 0;

	wrc_top #(.HALF_CYC(HC)) wrc_top_i (.MCLK_IN(clk), .NRST_IN(rst_n), .CE_IN(1'h1), .HSEL_IN(1'h1),
		.HADDR_IN(haddr), .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2), .HWDATA_IN(hwdata),
		.HREADY_IN(hready), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp),
		.VRECT_CONVERGED_IN(conv), .VRECT_ABOVE_UVLO_IN(uvlo), .LOAD_ABOVE_FULL_SYNC_IN(above),
		.LOAD_BELOW_FULL_SYNC_EXIT_IN(below), .IOUT_MA_IN(iout), .ENABLE_SELECT_A_IN(ena),
		.ENABLE_SELECT_B_IN(enb), .CHARGE_STATUS_N_OUT(charge_status_n), .CHARGE_STATUS_N_OE_OUT(chg_oe),
		.MODULATION_SWITCH_A_OUT(swa), .MODULATION_SWITCH_B_OUT(swb), .SUPPLY_OUT_EN_OUT(sup),
		.COMM_LIMIT_EN_OUT(lim_en), .COMM_LIMIT_MA_OUT(lim_ma), .RECT_MODE_OUT(rmode));
	wrc_tx_decoder #(.HALF(HC)) wrc_tx_decoder_i (.clk_in(clk), .rst_n_in(rst_n), .sw_a_in(swa),
		.sw_b_in(swb), .byte_valid_out(rx_v), .byte_out(rx_b), .err_out(rx_e));

	initial begin
		clk = 1'h0;
		forever #50 clk = ~clk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	always @(posedge clk) begin
		if (rx_v === 1'h1)
			rx_q.push_back(rx_b);
		if (rx_e === 1'h1)
			chk(32'h1, 32'h0);
	end

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		@(posedge clk);
		haddr <= a;
		hwrite <= 1'h1;
		htrans <= 2'h2;
		do @(posedge clk); while (hready !== 1'h1);
		htrans <= 2'h0;
		hwrite <= 1'h0;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'h1);
	endtask

	task automatic rd(input logic [31:0] a, output logic [31:0] d);
		@(posedge clk);
		haddr <= a;
		htrans <= 2'h2;
		do @(posedge clk); while (hready !== 1'h1);
		htrans <= 2'h0;
		do @(posedge clk); while (hready !== 1'h1);
		d = hrdata;
	endtask

	// waits for room in the hold so no byte is silently dropped
	task automatic send(input logic [8:0] v);
		for (int i = 0; i < 200; i++) begin
			rd({20'h0, OFF_STATUS}, s);
			if (s[1] === 1'h0)
				break;
		end
		wr({20'h0, OFF_TXDATA}, {23'h0, v});
	endtask

	task automatic wait_end;
		for (int i = 0; i < 400; i++) begin
			rd({20'h0, OFF_STATUS}, s);
			if (s[0] === 1'h0)
				break;
		end
		repeat (4 * HC) @(posedge clk);
	endtask

	task automatic exp_rx(input logic [7:0] b);
		logic [7:0] g;
		g = rx_q.size() != 0 ? rx_q.pop_front() : 8'hxx;
		chk({24'h0, g}, {24'h0, b});
	endtask

	task automatic t_reset;
		chk({chg_oe, charge_status_n, swa, swb, sup, lim_en, rmode}, 32'h0);
		chk({19'h0, lim_ma}, 32'h190);
		chk({hready, hresp}, 32'h2);
		$display("test reset done");
	endtask

	task automatic t_regs;
		wr(32'h0000_1000, 32'hffff_ffff);
		rd({20'h0, OFF_CTRL}, s);
		chk(s, CTRL_RESET);
		rd(32'h0000_0010, s);
		chk(s, 32'h0);
		$display("test regs done");
	endtask

	task automatic t_supply;
		wr({20'h0, OFF_CTRL}, 32'h1);
		repeat (4) @(posedge clk);
		chk(sup, 1'h0);
		chk(chg_oe, 1'h0);
		conv <= 1'h1;
		repeat (3) @(posedge clk);
		chk(sup, 1'h1);
		chk({chg_oe, charge_status_n}, 32'h2);
		rd({20'h0, OFF_STATUS}, s);
		chk(s[2], 1'h1);
		conv <= 1'h0;
		repeat (3) @(posedge clk);
		chk({chg_oe, sup}, 32'h0);
		conv <= 1'h1;
		$display("test supply done");
	endtask

	task automatic t_packet;
		send(9'h004);
		send(9'h0a5);
		send(9'h13c);
		repeat (20) @(posedge clk);
		chk(lim_en, 1'h1);
		chk({19'h0, lim_ma}, 32'h190);
		rd({20'h0, OFF_ILIM}, s);
		chk(s, 32'h190);
		wait_end();
		chk(lim_en, 1'h0);
		chk({swa, swb}, 32'h0);
		exp_rx(8'h04);
		exp_rx(8'ha5);
		exp_rx(8'h3c);
		chk(rx_q.size(), 32'h0);
		$display("test packet done");
	endtask

	task automatic t_ept;
		enb <= 1'h1;
		wr({20'h0, OFF_CTRL}, 32'h0303);
		repeat (30) @(posedge clk);
		chk(lim_en, 1'h0);
		rd({20'h0, OFF_CTRL}, s);
		chk(s, 32'h0301);
		wait_end();
		exp_rx(HDR_EPT);
		exp_rx(8'h03);
		enb <= 1'h0;
		$display("test end transfer done");
	endtask

	task automatic t_limit;
		iout <= 12'h12d;
		repeat (3) @(posedge clk);
		chk({19'h0, lim_ma}, 32'h15f);
		iout <= 12'h12c;
		repeat (3) @(posedge clk);
		chk({19'h0, lim_ma}, 32'h190);
		$display("test limit done");
	endtask

	task automatic t_rect;
		chk(rmode, RECT_DIODE);
		uvlo <= 1'h1;
		repeat (3) @(posedge clk);
		chk(rmode, RECT_HALF);
		above <= 1'h1;
		repeat (3) @(posedge clk);
		chk(rmode, RECT_FULL);
		above <= 1'h0;
		repeat (3) @(posedge clk);
		chk(rmode, RECT_FULL);
		below <= 1'h1;
		repeat (3) @(posedge clk);
		chk(rmode, RECT_HALF);
		$display("test rectifier done");
	endtask

	task automatic test_done;
		$display("checks=%0d errors=%0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial begin
		repeat (30000) @(posedge clk);
		num_errors++;
		test_done();
	end

	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1'h1;
		@(posedge clk);
		t_reset();
		t_regs();
		t_supply();
		t_packet();
		t_ept();
		t_limit();
		t_rect();
		test_done();
	end
endmodule
